// ===== tce_top.sv
// Trace capture with trigger, post-trigger countdown and freeze, plus event timer.
// Assumes target cycle strobe and comparator hits are synchronous to ref_clk_i.
// How it works
// - Capture starts when halted target is released
// - Store only cycles matching the qualifier
// - Circular store keeps newest 256 entries
// - Trigger then countdown, then freeze and break
// - Post-trigger delay is 1 to 255
// - Entry zero is the triggering cycle
// - Rejected trigger: entry zero is last qualified
// - Qualifier is comparator 3 while capturing
// - Comparator 1 starts wrapping 24-bit timer
// - Timer rate: microsecond, 100 ns, bus cycle
// - Comparator 2 stops and holds timer
// - Comparator 2 also triggers in timing mode
// - Comparators 0..2 selectable as triggers
// - Each entry holds 64 signals
// - Signals sampled once per cycle
`default_nettype none
module tce_top
    import tce_pkg::*;
(
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             ce_i,
    input  wire logic             bus_cycle_i,
    input  wire logic [SIG_W-1:0] sig_i,
    input  wire logic [3:0]       bp_hit_i,
    input  wire logic             target_run_i,
    input  wire logic [7:0]       addr_i,
    input  wire logic [31:0]      wdata_i,
    input  wire logic             wr_i,
    input  wire logic             rd_i,
    output var  logic [31:0]      rdata_o,
    output wire logic             break_o,
    output wire logic             bp3_break_o
);
    // Control registers
    logic [7:0]         ctrl;
    logic [7:0]         delay;
    logic [AW-1:0]      rd_idx;
    tce_state_t         state;
    logic [7:0]         post_cnt;
    logic [AW-1:0]      wptr;
    logic [AW-1:0]      trig_idx;
    logic [AW:0]        valid_cnt;
    logic               any_qual;
    logic               run_q;
    logic [TIMER_W-1:0] timer;
    logic               timer_on;
    logic [3:0]         presc;
    logic               rd_q;
    logic [7:0]         rd_addr_q;
    logic [SIG_W-1:0]   mem_rd;

    // Decodes
    wire       en        = ctrl[CTRL_EN];
    wire       timed     = ctrl[CTRL_TIMED];
    wire [1:0] rate      = ctrl[CTRL_RATE +: 2];
    wire [2:0] tsel      = ctrl[CTRL_TSEL +: 3];
    wire       wr_ctrl   = wr_i && (addr_i == REG_CTRL);
    wire       wr_delay  = wr_i && (addr_i == REG_DELAY);
    wire       wr_rdidx  = wr_i && (addr_i == REG_RDIDX);
    wire       new_en    = wr_ctrl && wdata_i[CTRL_EN];
    wire       released  = target_run_i && !run_q;
    wire       rearm     = new_en || (released && en);
    wire       qual      = bus_cycle_i && bp_hit_i[3] && state != TCE_IDLE
                           && state != TCE_FROZEN && target_run_i;
    wire       trig_sel  = |(bp_hit_i[2:0] & tsel) || (timed && bp_hit_i[2]);
    wire       trigger   = bus_cycle_i && trig_sel && state == TCE_ARMED;
    wire       last_post = qual && state == TCE_POST && post_cnt == delay - 8'h01;
    wire [AW-1:0] prev_ptr = wptr - 8'h01;

    // Breakpoint 3 acts as a normal break only while capture is off
    assign bp3_break_o = !en && bp_hit_i[3] && bus_cycle_i;
    assign break_o     = state == TCE_FROZEN;

    // Control register: enable, timing mode, timer rate, trigger select
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ctrl <= CTRL_RST;
        end else if (ce_i && wr_ctrl) begin
            ctrl <= wdata_i[7:0];
        end
    end

    // A zero delay is refused, so one cycle always follows the trigger
    wire delay_ok = wr_delay && (wdata_i[7:0] != 8'h00);

    // Post-trigger delay register
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            delay <= DELAY_RST;
        end else if (ce_i && delay_ok) begin
            delay <= wdata_i[7:0];
        end
    end

    // Readout index into the trace store
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            rd_idx <= '0;
        end else if (ce_i && wr_rdidx) begin
            rd_idx <= wdata_i[AW-1:0];
        end
    end

    // Capture switched off by a control write with the enable clear
    wire cap_off = wr_ctrl && !wdata_i[CTRL_EN];

    // Previous run level, for spotting a release of the target
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            run_q <= 1'b0;
        end else if (ce_i) begin
            run_q <= target_run_i;
        end
    end

    // Capture state machine; a frozen buffer waits for a re-arm
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state <= TCE_IDLE;
        end else if (ce_i) begin
            if (cap_off) begin
                state <= TCE_IDLE;
            end else if (rearm) begin
                state <= target_run_i ? TCE_ARMED : TCE_IDLE;
            end else begin
                case (state)
                    TCE_IDLE:   if (en && released) state <= TCE_ARMED;
                    TCE_ARMED:  if (trigger) state <= TCE_POST;
                    TCE_POST:   if (last_post) state <= TCE_FROZEN;
                    TCE_FROZEN: state <= TCE_FROZEN;
                    default:    state <= TCE_IDLE;
                endcase
            end
        end
    end

    // Entries are written only for qualified cycles outside a re-arm
    wire          store     = qual && !rearm;
    wire          cnt_full  = valid_cnt == 9'(DEPTH);
    wire          post_step = qual && state == TCE_POST;
    wire [AW-1:0] trig_slot = qual ? wptr : prev_ptr;

    // Write pointer wraps, so the oldest entry is overwritten
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            wptr <= '0;
        end else if (ce_i && store) begin
            wptr <= wptr + 8'h01;
        end
    end

    // Valid count saturates at the depth and restarts on re-arm
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            valid_cnt <= '0;
        end else if (ce_i) begin
            if (rearm) begin
                valid_cnt <= '0;
            end else if (store && !cnt_full) begin
                valid_cnt <= valid_cnt + 9'h001;
            end
        end
    end

    // Something stored since the last re-arm
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            any_qual <= 1'b0;
        end else if (ce_i) begin
            if (rearm) begin
                any_qual <= 1'b0;
            end else if (store) begin
                any_qual <= 1'b1;
            end
        end
    end

    // Physical slot of entry zero, latched at the trigger
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            trig_idx <= '0;
        end else if (ce_i && trigger && !rearm) begin
            trig_idx <= trig_slot;
        end
    end

    // Qualified cycles seen since the trigger
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            post_cnt <= '0;
        end else if (ce_i) begin
            if (rearm) begin
                post_cnt <= '0;
            end else if (post_step) begin
                post_cnt <= post_cnt + 8'h01;
            end
        end
    end

    // Timer prescaler ticks and rate selection
    wire tick_us    = presc == US_LAST;
    wire tick_100ns = presc == NS100_LAST;
    wire tick = (rate == TCE_RATE_US)    ? tick_us :
                (rate == TCE_RATE_100NS) ? tick_100ns :
                (rate == TCE_RATE_BUS)   ? bus_cycle_i : 1'b0;
    wire presc_wrap = (rate == TCE_RATE_US) ? tick_us : tick_100ns;

    // Start and stop events; stop wins over a tick in the same cycle
    wire timer_start = timed && bus_cycle_i && bp_hit_i[1] && !timer_on;
    wire timer_stop  = timed && bus_cycle_i && bp_hit_i[2] && timer_on;
    wire timer_step  = timer_on && tick && !timer_stop;

    // Prescaler restarts with the timer, so the first tick is a full period
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            presc <= '0;
        end else if (ce_i) begin
            if (timer_start || presc_wrap) begin
                presc <= 4'h0;
            end else begin
                presc <= presc + 4'h1;
            end
        end
    end

    // Timer running: started by comparator 1, stopped by comparator 2
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            timer_on <= 1'b0;
        end else if (ce_i) begin
            if (timer_start) begin
                timer_on <= 1'b1;
            end else if (timer_stop) begin
                timer_on <= 1'b0;
            end
        end
    end

    // Interval count, wrapping past its maximum; held once stopped
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            timer <= '0;
        end else if (ce_i) begin
            if (timer_start) begin
                timer <= '0;
            end else if (timer_step) begin
                timer <= timer + 24'h000001;
            end
        end
    end

    // Trace store, 64-bit entries
    tce_mem u_mem (
        .ref_clk_i (ref_clk_i),
        .ce_i      (ce_i),
        .we_i      (store),
        .waddr_i   (wptr),
        .wdata_i   (sig_i),
        .raddr_i   (rd_idx),
        .rdata_o   (mem_rd)
    );

    // Status word: any stored, timer running, capture state
    wire [31:0] status_w = {28'h0, any_qual, timer_on, state};

    // Read strobe and address held for the answer cycle
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            rd_q      <= 1'b0;
            rd_addr_q <= '0;
        end else if (ce_i) begin
            rd_q      <= rd_i;
            rd_addr_q <= addr_i;
        end
    end

    // Read mux, answered one cycle after the read strobe
    always_comb begin
        rdata_o = 32'h0;
        if (rd_q) begin
            case (rd_addr_q)
                REG_CTRL:    rdata_o = {24'h0, ctrl};
                REG_DELAY:   rdata_o = {24'h0, delay};
                REG_STATUS:  rdata_o = status_w;
                REG_COUNT:   rdata_o = {23'h0, valid_cnt};
                REG_TIMER:   rdata_o = {8'h0, timer};
                REG_RDIDX:   rdata_o = {24'h0, rd_idx};
                REG_DATA_LO: rdata_o = mem_rd[31:0];
                REG_DATA_HI: rdata_o = mem_rd[63:32];
                REG_TRIGIDX: rdata_o = {24'h0, trig_idx};
                default:     rdata_o = 32'h0;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== tce_pkg.sv
// Package for the trace capture and event timer block.
// Assumes a single 10 MHz clock domain and a plain register port.
`default_nettype none
package tce_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ        = 10_000_000;
    localparam int unsigned TICK_US_NS    = 1000;
    localparam int unsigned TICK_100NS_NS = 100;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int unsigned US_CYCLES     = (TICK_US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned NS100_CYCLES  = (TICK_100NS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  US_LAST       = 4'(US_CYCLES - 1);
    localparam logic [3:0]  NS100_LAST    = 4'(NS100_CYCLES - 1);

    // Buffer geometry
    localparam int unsigned DEPTH      = 256;
    localparam int unsigned AW         = 8;
    localparam int unsigned SIG_W      = 64;
    localparam int unsigned TIMER_W    = 24;

    // Register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_DELAY   = 8'h04;
    localparam logic [7:0] REG_STATUS  = 8'h08;
    localparam logic [7:0] REG_COUNT   = 8'h0c;
    localparam logic [7:0] REG_TIMER   = 8'h10;
    localparam logic [7:0] REG_RDIDX   = 8'h14;
    localparam logic [7:0] REG_DATA_LO = 8'h18;
    localparam logic [7:0] REG_DATA_HI = 8'h1c;
    localparam logic [7:0] REG_TRIGIDX = 8'h20;

    // Control field positions
    localparam int unsigned CTRL_EN    = 0;
    localparam int unsigned CTRL_TIMED = 1;
    localparam int unsigned CTRL_RATE  = 2;
    localparam int unsigned CTRL_TSEL  = 4;

    // Reset values
    localparam logic [7:0]  DELAY_RST  = 8'h01;
    localparam logic [7:0]  CTRL_RST   = 8'h00;

    // Timer rates
    typedef enum logic [1:0] {
        TCE_RATE_US    = 2'b00,
        TCE_RATE_100NS = 2'b01,
        TCE_RATE_BUS   = 2'b10
    } tce_rate_t;

    // Capture states
    typedef enum logic [1:0] {
        TCE_IDLE   = 2'b00,
        TCE_ARMED  = 2'b01,
        TCE_POST   = 2'b10,
        TCE_FROZEN = 2'b11
    } tce_state_t;
endpackage
`default_nettype wire

// ===== tce_mem.sv
// Trace store: 256 entries of 64 bits, one write and one registered read port.
// Assumes write and read share the block clock and enable.
`default_nettype none
module tce_mem
    import tce_pkg::*;
(
    input  wire logic             ref_clk_i,
    input  wire logic             ce_i,
    input  wire logic             we_i,
    input  wire logic [AW-1:0]    waddr_i,
    input  wire logic [SIG_W-1:0] wdata_i,
    input  wire logic [AW-1:0]    raddr_i,
    output var  logic [SIG_W-1:0] rdata_o
);
    logic [SIG_W-1:0] mem [DEPTH];

    // Write port and registered read
    always_ff @(posedge ref_clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem[waddr_i] <= wdata_i;
            end
            rdata_o <= mem[raddr_i];
        end
    end
endmodule
`default_nettype wire

// ===== tce_top_assertions.sv
// Port checker for tce_top, bound below the module.
// Assumes one clock, sync active-low reset, capture enable in CTRL bit 0.
`default_nettype none
module tce_chk
    import tce_pkg::*;
(
    input wire logic        ref_clk_i,
    input wire logic        rstn_i,
    input wire logic        ce_i,
    input wire logic        bus_cycle_i,
    input wire logic [3:0]  bp_hit_i,
    input wire logic        target_run_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic        break_o,
    input wire logic        bp3_break_o
);
    logic en_q;
    wire  ctl_wr = ce_i && wr_i && addr_i == REG_CTRL;
    // Capture enable as last written
    always_ff @(posedge ref_clk_i)
        if (!rstn_i) en_q <= 1'b0;
        else if (ctl_wr) en_q <= wdata_i[CTRL_EN];
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // Register read taken at this edge
    sequence s_rd(logic [7:0] a);
        ce_i && rd_i && addr_i == a;
    endsequence
    a_bp3_gated: assert property (bp3_break_o == (bp_hit_i[3] && bus_cycle_i && !en_q))
        else $error("qualifier break wrong");
    a_break_cause: assert property ($rose(break_o) |->
        $past(bus_cycle_i && bp_hit_i[3] && target_run_i)) else $error("freeze without cycle");
    a_break_hold: assert property (break_o && target_run_i && !ctl_wr |=> break_o)
        else $error("break dropped");
    a_rearm_clear: assert property (ctl_wr && wdata_i[CTRL_EN] |=> !break_o)
        else $error("break kept after re-enable");
    a_delay_range: assert property (s_rd(REG_DELAY) |=> rdata_o inside {[32'h1:32'hff]})
        else $error("delay out of range");
    a_count_max: assert property (s_rd(REG_COUNT) |=> rdata_o <= 32'h100)
        else $error("count above depth");
    a_timer_width: assert property (s_rd(REG_TIMER) |=> rdata_o[31:24] == 8'h0)
        else $error("timer wider than 24 bits");
    a_frozen_status: assert property (s_rd(REG_STATUS) ##1 $stable(break_o) |->
        (rdata_o[1:0] == 2'h3) == break_o) else $error("state and break disagree");
endmodule
bind tce_top tce_chk chk_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
    .bus_cycle_i(bus_cycle_i), .bp_hit_i(bp_hit_i), .target_run_i(target_run_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .break_o(break_o), .bp3_break_o(bp3_break_o));
`default_nettype wire

// ===== tce_tgt.sv
// Target model: bus cycle strobes, sampled signals and comparator hits.
// Assumes the bench drives run level, pace, qualifier and trigger requests.
`default_nettype none
module tce_tgt
    import tce_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             run_i,
    input  wire logic             slow_i,
    input  wire logic             qall_i,
    input  wire logic [2:0]       trig_i,
    output var  logic             bus_cycle_o,
    output var  logic [SIG_W-1:0] sig_o,
    output var  logic [3:0]       hit_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {bus_cycle_o, sig_o, hit_o} = '0;
    // Cycle every clock when prompt, about half when slow; signals are fresh random values every clock
    always @(posedge clk_i) begin
        bus_cycle_o <= run_i && (!slow_i || $urandom % 2 == 1);
        sig_o       <= {$urandom, $urandom};
        hit_o       <= {qall_i || $urandom % 2 == 1, trig_i};
    end
endmodule
`default_nettype wire

// ===== tb_trace_capture_event_timer.sv
// Bench for tce_top: capture, readout and event timer against a target model.
// Assumes tce_pkg, tce_tgt, tce_top and tce_chk are compiled before it.
`default_nettype none
module tb_trace_capture_event_timer;
    import tce_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 0, rstn = 0, wr = 0, rd = 0, run = 0, slow = 0, qall = 1, bc, brk;
    logic [2:0]  trig = 0;
    logic [3:0]  hit;
    logic [7:0]  addr = 0;
    logic [31:0] wd = 0, rdat, v, w, h;
    logic [63:0] sig, q[$];
    int          fails = 0, num_checks = 0, ti, post, dly, on = 0, tsel, n, e;
    initial forever #50 clk = ~clk;
    tce_tgt tgt_u (.clk_i(clk), .run_i(run), .slow_i(slow), .qall_i(qall), .trig_i(trig),
                   .bus_cycle_o(bc), .sig_o(sig), .hit_o(hit));
    tce_top dut_u (.ref_clk_i(clk), .rstn_i(rstn), .ce_i(1'b1), .bus_cycle_i(bc), .sig_i(sig),
                   .bp_hit_i(hit), .target_run_i(run), .addr_i(addr), .wdata_i(wd),
                   .wr_i(wr), .rd_i(rd), .rdata_o(rdat), .break_o(brk), .bp3_break_o());
    // Reference store: qualified cycles, trigger slot, post-trigger count
    always @(posedge clk) if (on && bc && run) begin
        if (hit[3]) q.push_back(sig);
        if (ti < 0 && (hit[2:0] & tsel[2:0]) != 0) ti = q.size() - 1;
        else if (ti >= 0 && hit[3] && ++post == dly) on = 0;
    end
    task results();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [63:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) {wr, addr, wd} <= {1'b1, a, d};
        @(posedge clk) wr <= 1'b0;
    endtask
    task rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk) rd <= 1'b0;
        #50 d = rdat;
    endtask
    // Halted target: set delay and mode, then release it
    task arm(input int m, input int d, input logic [31:0] c);
        wreg(REG_DELAY, d);
        wreg(REG_CTRL, c);
        q.delete();
        ti = -1;
        post = 0;
        dly = d;
        tsel = m;
        on = 1;
        qall <= 1'b1;
        run <= 1'b1;
        #1 chk(brk, 0);
    endtask
    task wbrk();
        for (int i = 0; i < 3000 && brk !== 1'b1; i++) @(posedge clk);
        chk(brk, 1);
        if (brk !== 1'b1) results();
    endtask
    initial begin
        void'($urandom(87771));
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rreg(REG_CTRL, v);
        chk(v, 0);
        wreg(REG_DELAY, 0);
        rreg(REG_DELAY, v);
        chk(v, 1);
        rreg(8'h3c, v);
        chk(v, 0);
        $display("register test done");
        // Each comparator as trigger; wrap, slow bus and longest delay among them
        for (int b = 0; b < 3; b++) begin
            slow <= b == 2;
            arm(1 << b, b == 2 ? 255 : 1 + $urandom % 8, 32'((1 << b) << 4 | 1));
            repeat (b == 1 ? 300 : 10 + $urandom % 20) @(posedge clk);
            qall <= b == 1;
            trig <= 3'(1 << b);
            for (int i = 0; i < 50 && ti < 0; i++) @(posedge clk);
            trig <= 3'h0;
            wbrk();
            run <= 1'b0;
            rreg(REG_STATUS, v);
            chk(v[1:0], 3);
            rreg(REG_COUNT, v);
            chk(v, q.size() > 256 ? 256 : q.size());
            rreg(REG_TRIGIDX, w);
            for (int k = -3; k <= dly; k++) if (ti + k >= 0 && q.size() - ti - k <= 256) begin
                wreg(REG_RDIDX, (w + k) & 255);
                rreg(REG_DATA_LO, v);
                rreg(REG_DATA_HI, h);
                chk({h, v}, q[ti + k]);
            end
            $display("capture test %0d done", b);
        end
        // Interval timer at each rate, comparator 2 as stop and trigger
        for (int r = 0; r < 3; r++) begin
            slow <= 1'b0;
            arm(4, 1, 32'(r << 2 | 3));
            n = 20 + $urandom % 60;
            @(posedge clk) trig <= 3'h2;
            @(posedge clk) trig <= 3'h0;
            repeat (n) @(posedge clk);
            trig <= 3'h4;
            @(posedge clk) trig <= 3'h0;
            wbrk();
            rreg(REG_TIMER, v);
            e = r == 0 ? (n + 1) / 10 : n + 1;
            chk(v + 1 >= e && v <= e + 1, 1);
            rreg(REG_TIMER, w);
            chk(w, v);
            run <= 1'b0;
            $display("timer test %0d done", r);
        end
        wreg(REG_CTRL, 0);
        run <= 1'b1;
        repeat (20) @(posedge clk);
        results();
    end
endmodule
`default_nettype wire
